// ### design/bank_decode_ctrl.sv
/*
  Controller end: drives one command per request with bank and address.
  Assumes the user holds each request for one cycle only.
*/
`timescale 1ns/1ps
`default_nettype none
module bank_decode_ctrl
  import bank_decode_pkg::*;
(
  input  wire logic                           clk_i,
  input  wire logic                           resetn_i,
  input  wire bank_decode_pkg::cmd_e          req_cmd_i,
  input  wire logic [bank_decode_pkg::BANK_W-1:0] req_bank_i,
  input  wire logic [bank_decode_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic                           req_wvalid_i,
  input  wire logic [bank_decode_pkg::DATA_W-1:0] req_wdata_i,
  input  wire logic                           req_wmask_i,
  bank_decode_if.controller                   link
);
  cmd_e              cmd_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              wv_reg;
  logic [DATA_W-1:0] wd_reg;
  logic              wm_reg;

  // Row, column or op-code all travel on the same address lines; bank on its own lines
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmd_reg  <= CMD_NOP;
      bank_reg <= '0;
      addr_reg <= ADDR_ZERO;
      wv_reg   <= 1'b0;
      wd_reg   <= DATA_ZERO;
      wm_reg   <= 1'b0;
    end
    else
    begin
      cmd_reg  <= req_cmd_i;
      bank_reg <= req_bank_i;
      addr_reg <= req_addr_i;
      wv_reg   <= req_wvalid_i;
      wd_reg   <= req_wdata_i;
      wm_reg   <= req_wmask_i;
    end
  end

  assign link.cmd                   = cmd_reg;
  assign link.bank_select_lines     = bank_reg;
  assign link.row_col_address_lines = addr_reg;
  assign link.wdata_valid           = wv_reg;
  assign link.wdata                 = wd_reg;
  assign link.write_mask_input      = wm_reg;
endmodule // bank_decode_ctrl
`default_nettype wire

// ### design/bank_decode_dev.sv
/*
  Device end: decodes each latched command into bank, row, column,
  mode-register and precharge actions.
  Assumes the controller shares clk_i; the x8 option is a port.
*/
// Notes on behaviour
// - Bank lines pick bank for four commands
// - Bank lines pick mode register on load
// - Read/write with line high auto-precharges bank
// - Precharge line low one bank, high all
// - Single precharge hits only the named bank
// - Activate carries row address to bank
// - Read/write carries column address
// - Mode load carries op-code into register
// - Mode register one bit picks mask/strobe
// - Masked write beats are discarded
`timescale 1ns/1ps
`default_nettype none
module bank_decode_dev
  import bank_decode_pkg::*;
(
  input  wire logic                                clk_i,
  input  wire logic                                resetn_i,
  input  wire logic                                is_x8_i,
  bank_decode_if.device                            link,
  output logic [bank_decode_pkg::NUM_BANKS-1:0]    bank_open_o,
  output logic [bank_decode_pkg::NUM_BANKS-1:0]    precharge_o,
  output logic [bank_decode_pkg::NUM_BANKS-1:0]    auto_precharge_o,
  output logic [bank_decode_pkg::BANK_W-1:0]       access_bank_o,
  output logic [bank_decode_pkg::ADDR_W-1:0]       row_addr_o,
  output logic [bank_decode_pkg::ADDR_W-1:0]       col_addr_o,
  output logic                                     rd_strobe_o,
  output logic                                     wr_strobe_o,
  output logic [bank_decode_pkg::MR_NUM-1:0]       mr_write_o,
  output logic [bank_decode_pkg::ADDR_W-1:0]       mr_opcode_o,
  output logic                                     termination_strobe_o,
  output logic                                     wbeat_valid_o,
  output logic [bank_decode_pkg::DATA_W-1:0]       wbeat_data_o
);
  cmd_e              cmd;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic              auto_precharge_line;
  logic [NUM_BANKS-1:0] bank_hot;
  logic              is_act;
  logic              is_rw;
  logic              is_pre;
  logic              is_mrs;
  logic [NUM_BANKS-1:0] pre_set;
  logic [NUM_BANKS-1:0] ap_set;
  logic [NUM_BANKS-1:0] open_next;
  logic [ADDR_W-1:0] mr1_reg;
  logic              strobe_mode;
  logic              beat_keep;

  assign cmd  = link.cmd;
  assign bank = link.bank_select_lines;
  assign addr = link.row_col_address_lines;
  assign auto_precharge_line = addr[AP_BIT];
  assign bank_hot = NUM_BANKS'(1) << bank;
  assign is_act = (cmd == CMD_ACTIVATE);
  assign is_rw  = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  assign is_pre = (cmd == CMD_PRECHARGE);
  assign is_mrs = (cmd == CMD_MODE_LOAD);
  // Only the named bank unless the line asks for all
  assign pre_set = !is_pre ? NO_BANKS :
                   (auto_precharge_line ? ALL_BANKS : bank_hot);
  assign ap_set  = (is_rw && auto_precharge_line) ? bank_hot : NO_BANKS;
  assign open_next = ((bank_open_o | (is_act ? bank_hot : NO_BANKS))
                      & ~pre_set) & ~ap_set;
  // Strobe function exists only on x8 parts; x4 always masks
  assign strobe_mode = is_x8_i && mr1_reg[TERMINATION_STROBE_BIT];
  assign beat_keep = link.wdata_valid && !(link.write_mask_input && !strobe_mode);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bank_open_o      <= NO_BANKS;
      precharge_o      <= NO_BANKS;
      auto_precharge_o <= NO_BANKS;
      access_bank_o    <= '0;
      row_addr_o       <= ADDR_ZERO;
      col_addr_o       <= ADDR_ZERO;
      rd_strobe_o      <= 1'b0;
      wr_strobe_o      <= 1'b0;
      mr_write_o       <= '0;
      mr_opcode_o      <= ADDR_ZERO;
      mr1_reg          <= ADDR_ZERO;
      wbeat_valid_o    <= 1'b0;
      wbeat_data_o     <= DATA_ZERO;
    end
    else
    begin
      bank_open_o      <= open_next;
      precharge_o      <= pre_set;
      auto_precharge_o <= ap_set;
      rd_strobe_o      <= (cmd == CMD_READ);
      wr_strobe_o      <= (cmd == CMD_WRITE);
      if (is_act || is_rw || is_pre)
        access_bank_o <= bank;
      if (is_act)
        row_addr_o <= addr;
      if (is_rw)
        col_addr_o <= addr;
      mr_write_o <= is_mrs ? MR_NUM'(1) << bank[1:0] : '0;
      if (is_mrs)
        mr_opcode_o <= addr;
      if (is_mrs && bank == MR_ONE)
        mr1_reg <= addr;
      wbeat_valid_o <= beat_keep;
      if (beat_keep)
        wbeat_data_o <= link.wdata;
    end
  end

  assign termination_strobe_o = strobe_mode;
endmodule // bank_decode_dev
`default_nettype wire

// ### design/bank_decode_if.sv
/*
  Command, address and write-data wires between controller and device.
  Assumes both ends share clk; the bench instantiates and joins them.
*/
`timescale 1ns/1ps
`default_nettype none
interface bank_decode_if;
  import bank_decode_pkg::*;
  cmd_e                cmd;
  logic [BANK_W-1:0]   bank_select_lines;
  logic [ADDR_W-1:0]   row_col_address_lines;
  logic                wdata_valid;
  logic [DATA_W-1:0]   wdata;
  logic                write_mask_input;

  modport controller (output cmd, bank_select_lines, row_col_address_lines,
                      wdata_valid, wdata, write_mask_input);
  modport device (input cmd, bank_select_lines, row_col_address_lines,
                  wdata_valid, wdata, write_mask_input);
endinterface
`default_nettype wire

// ### design/bank_decode_pkg.sv
/*
  Shared constants and types for the bank and address decode link.
  Assumes one 100 MHz clock common to both ends.
*/
package bank_decode_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 15;
  localparam int NUM_BANKS = 8;
  localparam int MR_NUM = 4;
  localparam int DATA_W = 8;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int TERMINATION_STROBE_BIT = 11;
  localparam logic [BANK_W-1:0] MR_ONE = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
  localparam logic [NUM_BANKS-1:0] ALL_BANKS = 8'hff;
  localparam logic [NUM_BANKS-1:0] NO_BANKS = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  typedef enum logic [2:0]
  {
    CMD_NOP       = 3'h0,
    CMD_ACTIVATE  = 3'h1,
    CMD_READ      = 3'h3,
    CMD_WRITE     = 3'h2,
    CMD_PRECHARGE = 3'h6,
    CMD_MODE_LOAD = 3'h7
  } cmd_e;
endpackage

// ### verification/bank_decode_props.sv
/*
  Checker for the bank and address decode link.
  Assumes the bench wires the link and device outputs in by name.
*/
`timescale 1ns/1ps
`default_nettype none
module bank_decode_props
  import bank_decode_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 resetn_i,
  input wire bank_decode_pkg::cmd_e cmd,
  input wire logic [2:0]           bank_select_lines,
  input wire logic [14:0]          row_col_address_lines,
  input wire logic                 wdata_valid,
  input wire logic                 write_mask_input,
  input wire logic [7:0]           precharge_o,
  input wire logic [7:0]           auto_precharge_o,
  input wire logic [14:0]          row_addr_o,
  input wire logic                 rd_strobe_o,
  input wire logic [3:0]           mr_write_o,
  input wire logic                 termination_strobe_o,
  input wire logic                 wbeat_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire rw = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  wire ap = row_col_address_lines[AP_BIT];
  AST_PRE_ONE: assert property (cmd == CMD_PRECHARGE && !ap |=>
    precharge_o == (8'h01 << $past(bank_select_lines))) else $error("single precharge");
  AST_PRE_ALL: assert property (cmd == CMD_PRECHARGE && ap |=> precharge_o == 8'hff)
    else $error("all-bank precharge");
  AST_AUTO_PRE: assert property (rw && ap |=>
    auto_precharge_o == (8'h01 << $past(bank_select_lines))) else $error("auto precharge");
  AST_NO_AUTO: assert property (rw && !ap |=> auto_precharge_o == 8'h00)
    else $error("stray auto precharge");
  AST_ROW: assert property (cmd == CMD_ACTIVATE |=> row_addr_o == $past(row_col_address_lines))
    else $error("row address");
  AST_MR_SEL: assert property (cmd == CMD_MODE_LOAD |=>
    mr_write_o == (4'h1 << $past(bank_select_lines[1:0]))) else $error("mode register select");
  AST_RD: assert property (cmd == CMD_READ |=> rd_strobe_o)
    else $error("read strobe");
  AST_MASK: assert property (wdata_valid && write_mask_input && !termination_strobe_o
    |=> !wbeat_valid_o) else $error("masked beat kept");
  COV_PRE_ALL: cover property (cmd == CMD_PRECHARGE && ap);
  COV_AUTO: cover property (rw && ap);
  COV_MASK: cover property (wdata_valid && write_mask_input);
endmodule // bank_decode_props
`default_nettype wire

// ### verification/dram_bank_addr_decode_tb_top.sv
/*
  Bench joining controller and device ends over the link.
  Assumes the two-cycle request to output latency of the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module dram_bank_addr_decode_tb_top;
  import bank_decode_pkg::*;
  logic clk_i = 0, resetn_i = 0, is_x8_i = 0, wv = 0, wm = 0;
  cmd_e c = CMD_NOP;
  logic [2:0] b = '0, access_bank_o;
  logic [14:0] a = '0, row_addr_o, col_addr_o, mr_opcode_o;
  logic [7:0] bank_open_o, precharge_o, auto_precharge_o, wbeat_data_o;
  logic [3:0] mr_write_o;
  logic rd_strobe_o, wr_strobe_o, termination_strobe_o, wbeat_valid_o;
  int num_errors = 0, tests_run = 0;
  always #5 clk_i = ~clk_i;
  bank_decode_if lnk();
  bank_decode_ctrl bank_decode_ctrl_i(.clk_i, .resetn_i, .req_cmd_i(c), .req_bank_i(b),
    .req_addr_i(a), .req_wvalid_i(wv), .req_wdata_i(a[7:0]), .req_wmask_i(wm),
    .link(lnk.controller));
  bank_decode_dev bank_decode_dev_i(.clk_i, .resetn_i, .is_x8_i, .link(lnk.device),
    .bank_open_o, .precharge_o, .auto_precharge_o, .access_bank_o, .row_addr_o, .col_addr_o,
    .rd_strobe_o, .wr_strobe_o, .mr_write_o, .mr_opcode_o, .termination_strobe_o,
    .wbeat_valid_o, .wbeat_data_o);
  bank_decode_props bank_decode_props_i(.clk_i, .resetn_i, .cmd(lnk.cmd),
    .bank_select_lines(lnk.bank_select_lines), .row_col_address_lines(lnk.row_col_address_lines),
    .wdata_valid(lnk.wdata_valid), .write_mask_input(lnk.write_mask_input), .precharge_o,
    .auto_precharge_o, .row_addr_o, .rd_strobe_o, .mr_write_o, .termination_strobe_o,
    .wbeat_valid_o);
  // One request cycle, then idle; outputs settle two edges later
  task automatic op(cmd_e oc, logic [2:0] ob, logic [14:0] oa, logic ov, logic om);
    @(negedge clk_i);
    c = oc; b = ob; a = oa; wv = ov; wm = om;
    @(negedge clk_i);
    c = CMD_NOP; wv = 0;
    @(negedge clk_i);
  endtask
  task automatic t_banks();
    for (int i = 0; i < 8; i++)
    begin
      op(CMD_ACTIVATE, 3'(i), 15'h7ff0 ^ 15'(i), 0, 0);
      `CHK("open", 1'b1, bank_open_o[i])
      `CHK("act bank", 3'(i), access_bank_o)
      `CHK("row", 15'h7ff0 ^ 15'(i), row_addr_o)
      op(CMD_PRECHARGE, 3'(i), 15'h0000, 0, 0);
      `CHK("pre", 8'h01 << i, precharge_o)
      `CHK("closed", 8'h00, bank_open_o)
    end
    op(CMD_ACTIVATE, 3'h3, 15'h0001, 0, 0);
    op(CMD_PRECHARGE, 3'h2, 15'h0400, 0, 0);
    `CHK("pre all", 8'hff, precharge_o)
    `CHK("all closed", 8'h00, bank_open_o)
    $display("banks done");
  endtask
  task automatic t_rw();
    for (int p = 0; p < 2; p++)
    begin
      op(CMD_READ, 3'h5, 15'h0013 | 15'(p << AP_BIT), 0, 0);
      `CHK("col", 15'h0013 | 15'(p << AP_BIT), col_addr_o)
      `CHK("rd strobe", 1'b1, rd_strobe_o)
      `CHK("ap rd", 8'(p << 5), auto_precharge_o)
      op(CMD_ACTIVATE, 3'h6, 15'h0100, 0, 0);
      op(CMD_WRITE, 3'h6, 15'h0021 | 15'(p << AP_BIT), 0, 0);
      `CHK("wr col", 15'h0021 | 15'(p << AP_BIT), col_addr_o)
      `CHK("wr strobe", 1'b1, wr_strobe_o)
      `CHK("wr bank", 3'h6, access_bank_o)
      `CHK("ap wr", 8'(p << 6), auto_precharge_o)
      `CHK("open after wr", p == 0, bank_open_o[6])
    end
    $display("read write done");
  endtask
  task automatic t_mode();
    for (int i = 0; i < 4; i++)
    begin
      op(CMD_MODE_LOAD, 3'(i), 15'h1230 + 15'(i), 0, 0);
      `CHK("mr sel", 4'h1 << i, mr_write_o)
      `CHK("opcode", 15'h1230 + 15'(i), mr_opcode_o)
    end
    $display("mode done");
  endtask
  task automatic t_mask();
    op(CMD_WRITE, 3'h0, 15'h0055, 1, 1);
    `CHK("masked", 1'b0, wbeat_valid_o)
    op(CMD_WRITE, 3'h0, 15'h00a6, 1, 0);
    `CHK("kept", 1'b1, wbeat_valid_o)
    `CHK("beat", 8'ha6, wbeat_data_o)
    op(CMD_MODE_LOAD, MR_ONE, 15'h0800, 0, 0);
    `CHK("x4 strobe", 1'b0, termination_strobe_o)
    is_x8_i = 1;
    op(CMD_WRITE, 3'h0, 15'h003c, 1, 1);
    `CHK("strobe", 1'b1, termination_strobe_o)
    `CHK("strobe beat", 1'b1, wbeat_valid_o)
    `CHK("strobe data", 8'h3c, wbeat_data_o)
    op(CMD_MODE_LOAD, MR_ONE, 15'h0000, 0, 0);
    `CHK("mask mode", 1'b0, termination_strobe_o)
    op(CMD_WRITE, 3'h0, 15'h0077, 1, 1);
    `CHK("remasked", 1'b0, wbeat_valid_o)
    `CHK("held data", 8'h3c, wbeat_data_o)
    $display("mask done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clk_i);
    resetn_i = 1;
    t_banks();
    t_rw();
    t_mode();
    t_mask();
    conclude();
  end
endmodule // dram_bank_addr_decode_tb_top
`default_nettype wire
